// File: bos_cpu_model.sv
// Purpose: Processor-side partner model of the board option strap logic
// Assumes: pclk domain; the bench calls halt and pulse_reinit right after a rising edge
// Notes: a tick request waits ack_wait plus one cycles for its acknowledge
`timescale 1ns/10ps
module bos_cpu_model (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       tick_irq_req,
	input  wire logic [3:0] ack_wait,
	output logic            halt_exec,
	output logic            kernel_mode,
	output logic            reinit,
	output logic            tick_ack
);
	logic [3:0] wait_q;

	initial begin
		halt_exec   = 1'b0;
		kernel_mode = 1'b0;
		reinit      = 1'b0;
	end

	// Acknowledge a pending tick request after ack_wait plus one cycles
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wait_q   <= 4'h0;
			tick_ack <= 1'b0;
		end else if (tick_irq_req && !tick_ack) begin
			wait_q   <= wait_q + 4'h1;
			tick_ack <= (wait_q >= ack_wait);
		end else begin
			wait_q   <= 4'h0;
			tick_ack <= 1'b0;
		end
	end

	// One-cycle halt instruction, kernel or user mode
	task automatic halt(input logic k);
		halt_exec   <= 1'b1;
		kernel_mode <= k;
		@(posedge pclk);
		halt_exec   <= 1'b0;
		kernel_mode <= 1'b0;
	endtask

	// One-cycle board reinitialisation
	task automatic pulse_reinit();
		reinit <= 1'b1;
		@(posedge pclk);
		reinit <= 1'b0;
	endtask
endmodule

// File: bos_pkg.sv
// Purpose: Constants, types and shared functions of the board option strap logic
// Assumes: 50 MHz pclk; every strap input reads 1 when its jumper is fitted
// Notes: Register offsets are APB byte addresses
package bos_pkg;

	localparam int unsigned BOS_CLK_HZ      = 50_000_000;
	localparam int unsigned BOS_TICK50_HZ   = 50;
	localparam int unsigned BOS_TICK60_HZ   = 60;
	localparam int unsigned BOS_TICK50_CYC  = BOS_CLK_HZ / BOS_TICK50_HZ;
	localparam int unsigned BOS_TICK60_CYC  = BOS_CLK_HZ / BOS_TICK60_HZ;
	localparam int unsigned BOS_TICK_CNT_W  = 20;
	localparam logic [1:0]  BOS_SETTLE_CYC  = 2'h3;

	localparam logic [7:0]  BOS_MAINT_OFS     = 8'h00;
	localparam logic [7:0]  BOS_CPUERR_OFS    = 8'h04;
	localparam logic [7:0]  BOS_RATE_CTRL_OFS = 8'h08;
	localparam logic [7:0]  BOS_RATE_STAT_OFS = 8'h0C;
	localparam logic [7:0]  BOS_TICK_CTRL_OFS = 8'h10;
	localparam logic [7:0]  BOS_IRQ_STAT_OFS  = 8'h14;
	localparam logic [7:0]  BOS_IRQ_MASK_OFS  = 8'h18;
	localparam logic [7:0]  BOS_BOOT_OFS      = 8'h1C;

	localparam int unsigned BOS_MAINT_HALT_BIT  = 3;
	localparam int unsigned BOS_MAINT_PWRUP_BIT = 2;
	localparam int unsigned BOS_CPUERR_HALT_BIT = 7;
	localparam int unsigned BOS_RATE_OVR_BIT    = 3;
	localparam int unsigned BOS_TICK_EN_BIT     = 0;
	localparam int unsigned BOS_IRQ_TICK_BIT    = 0;
	localparam int unsigned BOS_IRQ_HALT_BIT    = 1;
	localparam int unsigned BOS_IRQ_W           = 2;

	localparam int unsigned BOS_STRAP_W     = 7;
	localparam int unsigned BOS_S_HALT      = 0;
	localparam int unsigned BOS_S_PWRUP     = 1;
	localparam int unsigned BOS_S_ROM16     = 2;
	localparam int unsigned BOS_S_RATE_LO   = 3;
	localparam int unsigned BOS_S_RATE_HI   = 5;
	localparam int unsigned BOS_S_TICK60    = 6;

	localparam logic [15:0] BOS_HALT_VECTOR = 16'h0004;
	localparam logic [15:0] BOS_FW_PC       = 16'hF600;
	localparam logic [15:0] BOS_FW_PSW      = 16'h00E0;
	localparam logic [15:0] BOS_MON_PSW     = 16'h0000;
	localparam logic [15:0] BOS_BAUD_RST    = 16'h012C;
	localparam logic [2:0]  BOS_TICK_LEVEL  = 3'h6;
	localparam logic [4:0]  BOS_ROM_BITS_15 = 5'h0F;
	localparam logic [4:0]  BOS_ROM_BITS_16 = 5'h10;
	localparam logic [31:0] BOS_RESET_WORD  = 32'h0000_0000;

	typedef struct packed {
		logic [1:0]                settle;
		logic                      captured;
		logic                      boot_valid;
		logic                      boot_monitor;
		logic [15:0]               boot_pc;
		logic [15:0]               boot_psw;
		logic [2:0]                strap_rate;
		logic                      rate_ovr;
		logic [2:0]                sw_rate;
		logic [2:0]                baud_code;
		logic [15:0]               baud;
		logic                      rom16;
		logic [4:0]                rom_bits;
		logic                      err_halt;
		logic                      enter_mon;
		logic                      trap_req;
		logic [BOS_TICK_CNT_W-1:0] tick_cnt;
		logic                      tick;
		logic                      tick_en;
		logic                      tick_irq;
		logic [BOS_IRQ_W-1:0]      irq_stat;
		logic [BOS_IRQ_W-1:0]      irq_mask;
		logic                      irq;
		logic                      pready;
		logic                      pslverr;
		logic [31:0]               prdata;
	} bos_state_t;

	// Baud rate in bits per second for a 3-bit rate code
	function automatic logic [15:0] bos_baud(input logic [2:0] code);
		logic [15:0] r;
		case (code)
			3'h0: r = 16'h012C;
			3'h1: r = 16'h0258;
			3'h2: r = 16'h04B0;
			3'h3: r = 16'h0960;
			3'h4: r = 16'h12C0;
			3'h5: r = 16'h2580;
			3'h6: r = 16'h4B00;
			default: r = 16'h9600;
		endcase
		return r;
	endfunction

	function automatic logic bos_mapped(input logic [7:0] a);
		return (a == BOS_MAINT_OFS) || (a == BOS_CPUERR_OFS) || (a == BOS_RATE_CTRL_OFS) ||
		       (a == BOS_RATE_STAT_OFS) || (a == BOS_TICK_CTRL_OFS) || (a == BOS_IRQ_STAT_OFS) ||
		       (a == BOS_IRQ_MASK_OFS) || (a == BOS_BOOT_OFS);
	endfunction

endpackage

// File: bos_strap_logic.sv
// Purpose: Strap decode, halt response, boot choice, console baud and tick interrupt
// Assumes: APB slave with zero wait states; processor signals are in the pclk domain
// Notes: Straps read 1 when fitted
//
// Our own choices: the placing of the registers and the APB slave port.
`timescale 1ns/10ps
module bos_strap_logic
	import bos_pkg::*;
#(
	parameter int unsigned TICK50_CYC = BOS_TICK50_CYC,
	parameter int unsigned TICK60_CYC = BOS_TICK60_CYC
) (
	input  wire logic                   pclk,
	input  wire logic                   presetn,
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [7:0]             paddr,
	input  wire logic [31:0]            pwdata,
	output logic      [31:0]            prdata,
	output logic                        pready,
	output logic                        pslverr,
	input  wire logic                   strap_halt_fitted,
	input  wire logic                   strap_pwrup_fitted,
	input  wire logic                   strap_rom16_fitted,
	input  wire logic [2:0]             strap_rate_fitted,
	input  wire logic                   strap_tick60_fitted,
	input  wire logic                   halt_exec,
	input  wire logic                   kernel_mode,
	input  wire logic                   reinit,
	input  wire logic                   tick_ack,
	output logic                        enter_monitor,
	output logic                        halt_trap,
	output logic      [15:0]            trap_vector,
	output logic                        boot_valid,
	output logic                        boot_monitor,
	output logic      [15:0]            boot_pc,
	output logic      [15:0]            boot_psw,
	output logic                        rom_addr_16,
	output logic      [4:0]             rom_addr_bits,
	output logic      [2:0]             baud_code,
	output logic      [15:0]            baud_rate,
	output logic                        tick_irq_req,
	output logic      [2:0]             tick_irq_level,
	output logic                        irq
);

	localparam logic [BOS_TICK_CNT_W-1:0] LIM50 = BOS_TICK_CNT_W'(TICK50_CYC - 1);
	localparam logic [BOS_TICK_CNT_W-1:0] LIM60 = BOS_TICK_CNT_W'(TICK60_CYC - 1);

	bos_state_t            st_q;
	bos_state_t            st_d;
	logic [BOS_STRAP_W-1:0] strap_raw;
	logic [BOS_STRAP_W-1:0] strap_s;

	assign strap_raw = {strap_tick60_fitted, strap_rate_fitted, strap_rom16_fitted,
	                    strap_pwrup_fitted, strap_halt_fitted};

	bos_strap_sync #(
		.W       (BOS_STRAP_W)
	) u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.d       (strap_raw),
		.q       (strap_s)
	);

	logic                      halt_s;
	logic                      pwrup_s;
	logic [2:0]                rate_s;
	logic [BOS_TICK_CNT_W-1:0] tick_lim;
	logic                      wr_acc;
	logic                      rd_setup;
	logic                      kern_halt;

	assign halt_s    = strap_s[BOS_S_HALT];
	assign pwrup_s   = strap_s[BOS_S_PWRUP];
	assign rate_s    = strap_s[BOS_S_RATE_HI:BOS_S_RATE_LO];
	assign tick_lim  = strap_s[BOS_S_TICK60] ? LIM60 : LIM50;
	assign wr_acc    = psel && penable && pwrite && st_q.pready;
	assign rd_setup  = psel && !penable;
	assign kern_halt = halt_exec && kernel_mode;

	always_comb begin
		logic [BOS_IRQ_W-1:0] ev;
		logic                 ovr_next;
		st_d            = st_q;
		ev              = '0;
		ovr_next        = st_q.rate_ovr;
		st_d.boot_valid = 1'b0;
		st_d.enter_mon  = 1'b0;
		st_d.trap_req   = 1'b0;
		st_d.tick       = 1'b0;
		st_d.rom16      = strap_s[BOS_S_ROM16];
		st_d.rom_bits   = strap_s[BOS_S_ROM16] ? BOS_ROM_BITS_16 : BOS_ROM_BITS_15;

		// Boot choice and default rate taken once the synchroniser has settled
		if (!st_q.captured) begin
			st_d.settle = st_q.settle + 2'h1;
			if (st_q.settle == BOS_SETTLE_CYC) begin
				st_d.captured     = 1'b1;
				st_d.boot_valid   = 1'b1;
				st_d.boot_monitor = pwrup_s;
				st_d.boot_pc      = pwrup_s ? 16'h0000 : BOS_FW_PC;
				st_d.boot_psw     = pwrup_s ? BOS_MON_PSW : BOS_FW_PSW;
				st_d.strap_rate   = rate_s;
			end
		end else if (reinit) begin
			st_d.strap_rate = rate_s;
		end

		// Kernel halt response
		if (kern_halt && st_q.captured) begin
			if (halt_s) begin
				st_d.enter_mon = 1'b1;
			end else begin
				st_d.trap_req             = 1'b1;
				ev[BOS_IRQ_HALT_BIT]      = 1'b1;
			end
		end

		// Tick divider
		if (st_q.tick_cnt >= tick_lim) begin
			st_d.tick_cnt = '0;
			st_d.tick     = 1'b1;
		end else begin
			st_d.tick_cnt = st_q.tick_cnt + BOS_TICK_CNT_W'(1);
		end
		if (st_q.tick && st_q.tick_en) begin
			ev[BOS_IRQ_TICK_BIT] = 1'b1;
		end

		// APB setup phase: answer prepared for the access phase
		st_d.pready  = 1'b0;
		st_d.pslverr = 1'b0;
		if (rd_setup) begin
			st_d.pready  = 1'b1;
			st_d.pslverr = !bos_mapped(paddr);
			st_d.prdata  = BOS_RESET_WORD;
			if (!pwrite) begin
				if (paddr == BOS_MAINT_OFS) begin
					st_d.prdata[BOS_MAINT_HALT_BIT]  = halt_s;
					st_d.prdata[BOS_MAINT_PWRUP_BIT] = pwrup_s;
				end else if (paddr == BOS_CPUERR_OFS) begin
					st_d.prdata[BOS_CPUERR_HALT_BIT] = st_q.err_halt;
				end else if (paddr == BOS_RATE_CTRL_OFS) begin
					st_d.prdata[BOS_RATE_OVR_BIT] = st_q.rate_ovr;
					st_d.prdata[2:0]              = st_q.sw_rate;
				end else if (paddr == BOS_RATE_STAT_OFS) begin
					st_d.prdata[31:16] = st_q.baud;
					st_d.prdata[6:4]   = st_q.strap_rate;
					st_d.prdata[2:0]   = st_q.baud_code;
				end else if (paddr == BOS_TICK_CTRL_OFS) begin
					st_d.prdata[BOS_TICK_EN_BIT] = st_q.tick_en;
				end else if (paddr == BOS_IRQ_STAT_OFS) begin
					st_d.prdata[BOS_IRQ_W-1:0] = st_q.irq_stat;
				end else if (paddr == BOS_IRQ_MASK_OFS) begin
					st_d.prdata[BOS_IRQ_W-1:0] = st_q.irq_mask;
				end else if (paddr == BOS_BOOT_OFS) begin
					st_d.prdata[31:16] = st_q.boot_pc;
					st_d.prdata[15:8]  = st_q.boot_psw[7:0];
					st_d.prdata[1]     = st_q.boot_monitor;
					st_d.prdata[0]     = st_q.captured;
				end
			end
		end

		// APB access phase writes; hardware set wins over write-one-to-clear
		if (wr_acc) begin
			if (paddr == BOS_CPUERR_OFS) begin
				if (pwdata[BOS_CPUERR_HALT_BIT]) begin
					st_d.err_halt = 1'b0;
				end
			end else if (paddr == BOS_RATE_CTRL_OFS) begin
				ovr_next      = pwdata[BOS_RATE_OVR_BIT];
				st_d.rate_ovr = ovr_next;
				if (ovr_next) begin
					st_d.sw_rate = pwdata[2:0];
				end
			end else if (paddr == BOS_TICK_CTRL_OFS) begin
				st_d.tick_en = pwdata[BOS_TICK_EN_BIT];
			end else if (paddr == BOS_IRQ_STAT_OFS) begin
				st_d.irq_stat = st_q.irq_stat & ~pwdata[BOS_IRQ_W-1:0];
			end else if (paddr == BOS_IRQ_MASK_OFS) begin
				st_d.irq_mask = pwdata[BOS_IRQ_W-1:0];
			end
		end
		if (st_q.trap_req) begin
			st_d.err_halt = 1'b1;
		end
		st_d.irq_stat = st_d.irq_stat | ev;

		// Tick request to the processor, held until acknowledged
		if (st_q.tick && st_q.tick_en) begin
			st_d.tick_irq = 1'b1;
		end else if (tick_ack) begin
			st_d.tick_irq = 1'b0;
		end

		// Effective console rate
		st_d.baud_code = st_q.rate_ovr ? st_q.sw_rate : st_q.strap_rate;
		st_d.baud      = bos_baud(st_d.baud_code);
		st_d.irq       = |(st_d.irq_stat & st_d.irq_mask);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q           <= '0;
			st_q.boot_psw  <= BOS_MON_PSW;
			st_q.baud      <= BOS_BAUD_RST;
			st_q.rom_bits  <= BOS_ROM_BITS_15;
		end else begin
			st_q <= st_d;
		end
	end

	assign prdata         = st_q.prdata;
	assign pready         = st_q.pready;
	assign pslverr        = st_q.pslverr;
	assign enter_monitor  = st_q.enter_mon;
	assign halt_trap      = st_q.trap_req;
	assign trap_vector    = BOS_HALT_VECTOR;
	assign boot_valid     = st_q.boot_valid;
	assign boot_monitor   = st_q.boot_monitor;
	assign boot_pc        = st_q.boot_pc;
	assign boot_psw       = st_q.boot_psw;
	assign rom_addr_16    = st_q.rom16;
	assign rom_addr_bits  = st_q.rom_bits;
	assign baud_code      = st_q.baud_code;
	assign baud_rate      = st_q.baud;
	assign tick_irq_req   = st_q.tick_irq;
	assign tick_irq_level = BOS_TICK_LEVEL;
	assign irq            = st_q.irq;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_halt_monitor: assert property (kern_halt && st_q.captured && halt_s |=> enter_monitor && !halt_trap)
		else $error("kernel halt with strap fitted did not enter monitor");
	a_halt_trap: assert property (kern_halt && st_q.captured && !halt_s |=> halt_trap ##1 st_q.err_halt)
		else $error("kernel halt without strap did not trap and flag");
	a_maint_halt: assert property (rd_setup && !pwrite && paddr == BOS_MAINT_OFS |=> prdata[3] == $past(halt_s))
		else $error("maintenance bit 3 does not show halt strap");
	a_maint_pwrup: assert property (rd_setup && !pwrite && paddr == BOS_MAINT_OFS |=> prdata[2] == $past(pwrup_s))
		else $error("maintenance bit 2 does not show power-up strap");
	a_boot_mon: assert property (boot_valid && boot_monitor |-> boot_psw == 16'h0000)
		else $error("monitor boot without cleared status");
	a_boot_fw: assert property (boot_valid && !boot_monitor |-> boot_pc == 16'hF600 && boot_psw == 16'h00E0)
		else $error("firmware boot with wrong start values");
	a_rom_width: assert property (##1 rom_addr_bits == ($past(strap_s[BOS_S_ROM16]) ? 5'h10 : 5'h0F))
		else $error("firmware address width does not follow strap");
	a_rate_load: assert property ($rose(st_q.captured) |-> st_q.strap_rate == $past(rate_s))
		else $error("default rate not loaded from straps");
	a_rate_keep: assert property (!st_q.rate_ovr |=> baud_code == $past(st_q.strap_rate))
		else $error("rate changed without override");
	a_baud_map: assert property (baud_code == 3'h5 |-> baud_rate == 16'h2580)
		else $error("rate code 5 is not 9600 baud");
	a_tick_irq: assert property (st_q.tick && st_q.tick_en |=> tick_irq_req ##0 tick_irq_level == 3'h6)
		else $error("tick did not raise level 6 request");
	a_tick_range: assert property (st_q.tick |-> $past(st_q.tick_cnt) == $past(tick_lim))
		else $error("tick not at selected period");
	a_capture_once: assert property ($rose(st_q.captured) |-> boot_valid ##1 !boot_valid[*2])
		else $error("boot choice not a single capture");
	a_user_halt: assert property (halt_exec && !kernel_mode |=> !enter_monitor && !halt_trap)
		else $error("non-kernel halt was acted on");
	a_halt_early: assert property (kern_halt && !st_q.captured |=> !enter_monitor && !halt_trap)
		else $error("halt acted on before strap capture");
	a_err_set_wins: assert property (st_q.trap_req |=> st_q.err_halt)
		else $error("halt trap did not set error bit 7");
	a_halt_event: assert property (halt_trap |-> st_q.irq_stat[BOS_IRQ_HALT_BIT])
		else $error("halt trap did not set its status bit");
	a_rate_guard: assert property (wr_acc && !pwdata[BOS_RATE_OVR_BIT] |=> $stable(st_q.sw_rate))
		else $error("software rate written without override bit");
	a_rate_sw_use: assert property (st_q.rate_ovr |=> baud_code == $past(st_q.sw_rate))
		else $error("override set but software rate not used");
	a_rate_reinit: assert property (st_q.captured && reinit |=> st_q.strap_rate == $past(rate_s))
		else $error("reinit did not reload strapped rate");
	a_rate_static: assert property (st_q.captured && !reinit |=> $stable(st_q.strap_rate))
		else $error("strapped rate changed without reinit");
	a_baud_map0: assert property (baud_code == 3'h0 |-> baud_rate == 16'h012C)
		else $error("rate code 0 is not 300 baud");
	a_baud_map1: assert property (baud_code == 3'h1 |-> baud_rate == 16'h0258)
		else $error("rate code 1 is not 600 baud");
	a_baud_map2: assert property (baud_code == 3'h2 |-> baud_rate == 16'h04B0)
		else $error("rate code 2 is not 1200 baud");
	a_baud_map3: assert property (baud_code == 3'h3 |-> baud_rate == 16'h0960)
		else $error("rate code 3 is not 2400 baud");
	a_baud_map4: assert property (baud_code == 3'h4 |-> baud_rate == 16'h12C0)
		else $error("rate code 4 is not 4800 baud");
	a_baud_map6: assert property (baud_code == 3'h6 |-> baud_rate == 16'h4B00)
		else $error("rate code 6 is not 19200 baud");
	a_baud_map7: assert property (baud_code == 3'h7 |-> baud_rate == 16'h9600)
		else $error("rate code 7 is not 38400 baud");
	a_tick_off: assert property (!st_q.tick_en && !tick_irq_req |=> !tick_irq_req)
		else $error("tick request raised while disabled");
	a_tick_hold: assert property (tick_irq_req && !tick_ack |=> tick_irq_req)
		else $error("tick request dropped before acknowledge");
	a_tick_event: assert property (st_q.tick && st_q.tick_en |=> st_q.irq_stat[BOS_IRQ_TICK_BIT])
		else $error("enabled tick did not set its status bit");
	a_tick_single: assert property (st_q.tick |=> !st_q.tick)
		else $error("tick lasted more than one cycle");
	a_boot_choice: assert property (boot_valid |-> boot_monitor == $past(pwrup_s))
		else $error("boot choice does not follow power-up strap");
	a_sync_halt: assert property (st_q.captured |-> halt_s == $past(strap_halt_fitted, 2))
		else $error("halt strap not passed through two flops");
	a_sync_rate: assert property (st_q.captured |-> rate_s == $past(strap_rate_fitted, 2))
		else $error("rate straps not passed through two flops");

endmodule

// File: bos_strap_sync.sv
// Purpose: Two-flop synchroniser for the board straps
// Assumes: Straps are static after power-up
// Notes: Only the second stage leaves this module
`timescale 1ns/10ps
module bos_strap_sync
	import bos_pkg::*;
#(
	parameter int unsigned W = BOS_STRAP_W
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] sync;
	} bos_sync_t;

	bos_sync_t s_q;
	bos_sync_t s_d;

	always_comb begin
		s_d      = s_q;
		s_d.meta = d;
		s_d.sync = s_q.meta;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign q = s_q.sync;

endmodule

// File: bos_tb.sv
// Purpose: Self-checking bench of the board option strap logic
// Assumes: Tick counts shortened to 20 and 16 cycles
// Notes: Registers reached over APB; processor side played by the partner model
`timescale 1ns/10ps
module testbench;
	import bos_pkg::*;
	localparam int unsigned T50 = 20;
	localparam int unsigned T60 = 16;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata;
	logic        strap_halt_fitted, strap_pwrup_fitted, strap_rom16_fitted, strap_tick60_fitted;
	logic [2:0]  strap_rate_fitted, baud_code, tick_irq_level;
	logic        halt_exec, kernel_mode, reinit, tick_ack, enter_monitor, halt_trap, boot_valid;
	logic        boot_monitor, rom_addr_16, tick_irq_req, irq;
	logic [15:0] trap_vector, boot_pc, boot_psw, baud_rate;
	logic [4:0]  rom_addr_bits;
	logic [3:0]  ack_wait;
	int          n_mismatch = 0;
	int          check_count = 0;

	bos_strap_logic #(.TICK50_CYC(T50), .TICK60_CYC(T60)) DUT (
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.strap_halt_fitted, .strap_pwrup_fitted, .strap_rom16_fitted, .strap_rate_fitted,
		.strap_tick60_fitted, .halt_exec, .kernel_mode, .reinit, .tick_ack, .enter_monitor,
		.halt_trap, .trap_vector, .boot_valid, .boot_monitor, .boot_pc, .boot_psw, .rom_addr_16,
		.rom_addr_bits, .baud_code, .baud_rate, .tick_irq_req, .tick_irq_level, .irq
	);
	bos_cpu_model cpu (.pclk, .presetn, .tick_irq_req, .ack_wait, .halt_exec, .kernel_mode, .reinit, .tick_ack);

	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	// One APB transfer: setup, then access until pready
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		int n;
		n = 0;
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1);
		chk("pready", 32'h1, {31'h0, pready});
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask

	task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 32'h0, r, e);
		chk(what, exp, r & m);
	endtask

	task automatic count(input int cyc, output int nm, output int nt);
		nm = 0;
		nt = 0;
		repeat (cyc) begin
			@(posedge pclk);
			nm += int'(enter_monitor === 1'b1);
			nt += int'(halt_trap === 1'b1);
		end
	endtask

	task automatic boot(input logic h, input logic p, input logic r16, input logic [2:0] rc, input logic t6);
		int n;
		n = 0;
		strap_halt_fitted   <= h;
		strap_pwrup_fitted  <= p;
		strap_rom16_fitted  <= r16;
		strap_rate_fitted   <= rc;
		strap_tick60_fitted <= t6;
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (boot_valid !== 1'b1 && n < 20);
		chk("boot_valid", 32'h1, {31'h0, boot_valid});
		chk("boot_monitor", {31'h0, p}, {31'h0, boot_monitor});
		chk("boot_psw", p ? 32'h0 : 32'hE0, {16'h0, boot_psw});
		if (!p) chk("boot_pc", 32'hF600, {16'h0, boot_pc});
		repeat (2) @(posedge pclk);
		chk("rom_addr_bits", r16 ? 32'h10 : 32'h0F, {27'h0, rom_addr_bits});
		chk("rom_addr_16", {31'h0, r16}, {31'h0, rom_addr_16});
		chk("boot baud", 32'h12C << rc, {16'h0, baud_rate});
		rd_chk("maint", BOS_MAINT_OFS, 32'hC, {28'h0, h, p, 2'h0});
		rd_chk("boot reg", BOS_BOOT_OFS, 32'hFFFF_FF03, {p ? 16'h0 : 16'hF600, p ? 8'h0 : 8'hE0, 6'h0, p, 1'b1});
		$display("test boot done");
	endtask

	task automatic t_halt(input logic fit);
		int nm;
		int nt;
		cpu.halt(1'b0);
		count(6, nm, nt);
		chk("user halt", 32'h0, 32'(nm + nt));
		cpu.halt(1'b1);
		count(6, nm, nt);
		chk("monitor entries", {31'h0, fit}, 32'(nm));
		chk("halt traps", {31'h0, !fit}, 32'(nt));
		chk("trap_vector", 32'h4, {16'h0, trap_vector});
		rd_chk("cpu error", BOS_CPUERR_OFS, 32'h80, fit ? 32'h0 : 32'h80);
		rd_chk("halt status", BOS_IRQ_STAT_OFS, 32'h2, fit ? 32'h0 : 32'h2);
		wr(BOS_CPUERR_OFS, 32'h80);
		wr(BOS_IRQ_STAT_OFS, 32'h2);
		rd_chk("cpu error clear", BOS_CPUERR_OFS, 32'h80, 32'h0);
		$display("test halt done");
	endtask

	task automatic t_unmapped();
		logic [31:0] r;
		logic        e;
		apb(1'b0, 8'h20, 32'h0, r, e);
		chk("unmapped error", 32'h1, {31'h0, e});
		chk("unmapped data", 32'h0, r);
		wr(BOS_MAINT_OFS, 32'h0);
		rd_chk("maint read only", BOS_MAINT_OFS, 32'hC, 32'hC);
		$display("test unmapped done");
	endtask

	task automatic t_tick(input logic six);
		int t;
		int last;
		int gap;
		logic prev;
		t = 0;
		last = -1;
		gap = 0;
		prev = 1'b0;
		repeat (2 * T50) begin
			@(posedge pclk);
			t += int'(tick_irq_req === 1'b1);
		end
		chk("tick while disabled", 32'h0, 32'(t));
		wr(BOS_TICK_CTRL_OFS, 32'h1);
		for (int i = 0; i < 4 * T50; i++) begin
			@(posedge pclk);
			if (tick_irq_req === 1'b1 && !prev) begin
				if (last >= 0) gap = i - last;
				last = i;
			end
			prev = (tick_irq_req === 1'b1);
		end
		chk("tick period", six ? 32'(T60) : 32'(T50), 32'(gap));
		chk("tick level", 32'h6, {29'h0, tick_irq_level});
		wr(BOS_TICK_CTRL_OFS, 32'h0);
		rd_chk("tick status", BOS_IRQ_STAT_OFS, 32'h1, 32'h1);
		chk("irq masked", 32'h0, {31'h0, irq});
		wr(BOS_IRQ_MASK_OFS, 32'h1);
		@(posedge pclk);
		chk("irq unmasked", 32'h1, {31'h0, irq});
		wr(BOS_IRQ_STAT_OFS, 32'h1);
		@(posedge pclk);
		chk("irq cleared", 32'h0, {31'h0, irq});
		wr(BOS_IRQ_MASK_OFS, 32'h0);
		$display("test tick done");
	endtask

	task automatic t_baud();
		for (int c = 0; c < 8; c++) begin
			strap_rate_fitted <= 3'(c);
			repeat (4) @(posedge pclk);
			chk("code held", 32'((c + 7) % 8), {29'h0, baud_code});
			cpu.pulse_reinit();
			repeat (3) @(posedge pclk);
			chk("baud code", 32'(c), {29'h0, baud_code});
			chk("baud rate", 32'h12C << c, {16'h0, baud_rate});
		end
		wr(BOS_RATE_CTRL_OFS, 32'h5);
		rd_chk("no override", BOS_RATE_STAT_OFS, 32'hFFFF_0077, 32'h9600_0077);
		wr(BOS_RATE_CTRL_OFS, 32'hD);
		rd_chk("override", BOS_RATE_STAT_OFS, 32'hFFFF_0077, 32'h2580_0075);
		wr(BOS_RATE_CTRL_OFS, 32'h0);
		rd_chk("revert", BOS_RATE_STAT_OFS, 32'hFFFF_0077, 32'h9600_0077);
		$display("test baud done");
	endtask

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	initial begin
		repeat (5000) @(posedge pclk);
		n_mismatch++;
		give_verdict();
	end

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		strap_halt_fitted = 1'b0;
		strap_pwrup_fitted = 1'b0;
		strap_rom16_fitted = 1'b0;
		strap_rate_fitted = 3'h0;
		strap_tick60_fitted = 1'b0;
		ack_wait = 4'h0;
		@(posedge pclk);
		boot(1'b1, 1'b1, 1'b1, 3'h7, 1'b1);
		t_halt(1'b1);
		t_unmapped();
		t_tick(1'b1);
		t_baud();
		ack_wait <= 4'h8;
		boot(1'b0, 1'b0, 1'b0, 3'h2, 1'b0);
		t_halt(1'b0);
		t_tick(1'b0);
		give_verdict();
	end
endmodule
